// file: logic/pwm_defines.svh
// register offsets, bit positions and reset values of the pwm timer
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH
// byte offsets on the bus
`define OFS_SEL   8'h00
`define OFS_DUTY  8'h04
`define OFS_PHASE 8'h08
`define OFS_OE    8'h0c
`define OFS_PCLK  8'h10
`define OFS_ROUTE 8'h14
`define OFS_STC   8'h18
`define OFS_DIR   8'h1c
`define OFS_PDATA 8'h20
// clock_and_data_select fields
`define SEL_CKE   7
`define SEL_CKS   6
`define SEL_ONE   5
`define SEL_ZERO  4
// peripheral_clock_select prescale fields
`define PCLK_HI   2
`define PCLK_LO   1
// port_route_control fields
`define ROUTE_A   2
`define ROUTE_B   1
// serial_timer_control flash window bit
`define STC_FLASH 3
// reset values and the word transfer size accepted on the bus
`define RST_BYTE  8'h00
`define RST_NIB   4'h0
`define WORD_SIZE 3'h2
`endif

// file: logic/pwm_pkg.sv
// types shared by the pwm timer
package pwm_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_RDWAIT = 2'b01
  } bus_state_t;
  typedef struct packed {
    logic       inrange;
    logic [7:0] addr;
  } bus_req_t;
  typedef struct packed {
    logic oe;
    logic lvl;
  } pin_t;
endpackage

// file: logic/pwm_timer.sv
// eight channel pulse division pwm timer with ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "pwm_defines.svh"

// What this block does
// - eight outputs 15..8; outputs 15..12 go to primary or alternate pin
// - enable 0 stops clock; select 0 system clock; else divide by 2,4,8,16
// - one resolution step equals one selected counter clock period
// - conversion period is 256 steps; counter walks 256 states
// - basic pulse repeats sixteen times per conversion period
// - select register bit 5 reads 1, bit 4 reads 0, writes ignored
// - four bit select code 1000..1111 picks channel 8..15; 0xxx does nothing
// - eight independent readable writable 8-bit duty registers
// - upper duty nibble sets basic pulse width 0/16..15/16
// - lower duty nibble sets number of added pulses over sixteen basic pulses
// - active fraction per period equals duty value over 256
// - one phase bit per channel, bits map to outputs 15..8
// - phase 0 duty sets high width; phase 1 inverts output
// - enable and select reset to 0, counter clock off after reset
// - added pulse is one step just before basic rising edge, also for zero
// - added pulses fill basic pulses 15,7,11,3,13,5,9,1,14,6,10,2,12,4,8
// - direction 0 input; 1 with drive 0 port output; 1 with drive 1 waveform
module pwm_timer
  import pwm_pkg::*;
#(
  parameter int NCH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // primary pins of channels 15..8
  output logic [NCH-1:0]        pulse_outputs,
  output logic [NCH-1:0]        pulse_outputs_oe,
  // alternate pins of channels 15..12
  output logic [3:0]            alternate_pulse_outputs,
  output logic [3:0]            alternate_pulse_outputs_oe
);

  // decode of a captured address against one offset
  function automatic logic hit(input bus_req_t r, input logic [7:0] ofs);
    return r.inrange && (r.addr == ofs);
  endfunction
  // bit reversal orders the added pulse slots
  function automatic logic [3:0] rev4(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction

  logic                  counter_clock_enable;
  logic                  counter_clock_divided;
  logic [3:0]            data_sel;
  logic [NCH-1:0][7:0]   duty_value;
  logic [NCH-1:0]        phase_invert_bits;
  logic [NCH-1:0]        waveform_drive_bits;
  logic [7:0]            peripheral_clock_select;
  logic [1:0]            port_route_control;
  logic [7:0]            serial_timer_control;
  logic [NCH-1:0]        port_dir;
  logic [NCH-1:0]        port_data;
  bus_req_t              req;
  logic                  wr_v;
  bus_state_t            state;
  logic [7:0]            rd_val;
  logic [3:0]            div;
  logic [3:0]            div_mask;
  logic                  tick;
  logic [7:0]            shared_counter;
  logic [NCH-1:0]        raw;
  logic                  take;
  logic                  flash_on;
  assign take     = hsel && htrans[1] && hready && (hsize == `WORD_SIZE);
  assign flash_on = serial_timer_control[`STC_FLASH];

  // address phase capture; writes land one cycle later with hwdata
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req  <= '0;
      wr_v <= 1'b0;
    end else begin
      wr_v <= take && hwrite;
      if (take) begin
        req.inrange <= (haddr[31:8] == 24'h000000);
        req.addr    <= haddr[7:0];
      end
    end
  end

  // clock and data select; bits 5 and 4 have no storage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      counter_clock_enable  <= 1'b0;
      counter_clock_divided <= 1'b0;
      data_sel              <= `RST_NIB;
    end else if (wr_v && hit(req, `OFS_SEL)) begin
      counter_clock_enable  <= hwdata[`SEL_CKE];
      counter_clock_divided <= hwdata[`SEL_CKS];
      data_sel              <= hwdata[3:0];
    end
  end

  // duty registers behind the shared window, one per channel
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_duty
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          duty_value[gi] <= `RST_BYTE;
        end else if (wr_v && hit(req, `OFS_DUTY) && data_sel == {1'b1, 3'(gi)}) begin
          duty_value[gi] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  // phase, drive enable, direction and port data banks
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_invert_bits   <= `RST_BYTE;
      waveform_drive_bits <= `RST_BYTE;
      port_dir            <= `RST_BYTE;
      port_data           <= `RST_BYTE;
    end else if (wr_v) begin
      if (hit(req, `OFS_PHASE)) begin
        phase_invert_bits <= hwdata[7:0];
      end
      if (hit(req, `OFS_OE)) begin
        waveform_drive_bits <= hwdata[7:0];
      end
      if (hit(req, `OFS_DIR)) begin
        port_dir <= hwdata[7:0];
      end
      if (hit(req, `OFS_PDATA)) begin
        port_data <= hwdata[7:0];
      end
    end
  end

  // clock select is locked while the flash window is open
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      peripheral_clock_select <= `RST_BYTE;
    end else if (wr_v && hit(req, `OFS_PCLK) && !flash_on) begin
      peripheral_clock_select <= hwdata[7:0];
    end
  end

  // routing and serial timer control
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      port_route_control   <= 2'b00;
      serial_timer_control <= `RST_BYTE;
    end else if (wr_v) begin
      if (hit(req, `OFS_ROUTE)) begin
        port_route_control <= {hwdata[`ROUTE_A], hwdata[`ROUTE_B]};
      end
      if (hit(req, `OFS_STC)) begin
        serial_timer_control <= hwdata[7:0];
      end
    end
  end

  // read value of the captured address; unmapped reads give zero
  always_comb begin
    rd_val = 8'h00;
    if (req.inrange) begin
      case (req.addr)
        `OFS_SEL:   rd_val = {counter_clock_enable, counter_clock_divided, 1'b1, 1'b0, data_sel};
        `OFS_DUTY:  rd_val = data_sel[3] ? duty_value[data_sel[2:0]] : 8'h00;
        `OFS_PHASE: rd_val = phase_invert_bits;
        `OFS_OE:    rd_val = waveform_drive_bits;
        `OFS_PCLK:  rd_val = flash_on ? 8'h00 : peripheral_clock_select;
        `OFS_ROUTE: rd_val = {5'h00, port_route_control, 1'b0};
        `OFS_STC:   rd_val = serial_timer_control;
        `OFS_DIR:   rd_val = port_dir;
        `OFS_PDATA: rd_val = port_data;
        default:    rd_val = 8'h00;
      endcase
    end
  end

  // one wait state on reads, so a write just before is already visible
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state     <= BUS_IDLE;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else begin
      case (state)
        BUS_IDLE: begin
          if (take && !hwrite) begin
            state     <= BUS_RDWAIT;
            hreadyout <= 1'b0;
          end
        end
        BUS_RDWAIT: begin
          state     <= BUS_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= {24'h000000, rd_val};
        end
        default: begin
          state     <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // prescale mask: tick when the low bits of div are all ones
  always_comb begin
    case ({peripheral_clock_select[`PCLK_HI], peripheral_clock_select[`PCLK_LO]})
      2'b00:   div_mask = 4'h1;
      2'b01:   div_mask = 4'h3;
      2'b10:   div_mask = 4'h7;
      default: div_mask = 4'hf;
    endcase
  end
  assign tick = counter_clock_enable &&
                (!counter_clock_divided || ((div & div_mask) == div_mask));
  // free running divider; a mode change may give one short first step
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div <= `RST_NIB;
    end else begin
      div <= div + 4'h1;
    end
  end

  // shared time base, wraps after 256 steps
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shared_counter <= `RST_BYTE;
    end else if (tick) begin
      shared_counter <= shared_counter + 8'h01;
    end
  end

  // per channel waveform: high part ends each 16 step basic pulse
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_wave
      logic [3:0] upper;
      logic [3:0] lower;
      logic [3:0] pos;
      logic       basic;
      logic       extra;
      assign upper = duty_value[gi][7:4];
      assign lower = duty_value[gi][3:0];
      assign pos   = shared_counter[3:0];
      assign basic = pos > (4'hf - upper);
      // added step sits just before the rising edge, even when upper is zero
      assign extra = (pos == (4'hf - upper)) && (rev4(~shared_counter[7:4]) < lower);
      assign raw[gi] = basic || extra;
    end
  endgenerate
  // pin drivers; all pins come from flip-flops
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_pin
      logic alt;
      pin_t next_pin;
      if (gi >= 6) begin : g_a
        assign alt = port_route_control[1];
      end else if (gi >= 4) begin : g_b
        assign alt = port_route_control[0];
      end else begin : g_n
        assign alt = 1'b0;
      end
      // direction 0 leaves the pin to the port input
      assign next_pin.oe  = port_dir[gi];
      assign next_pin.lvl = waveform_drive_bits[gi] ?
                            (raw[gi] ^ phase_invert_bits[gi]) : port_data[gi];
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          pulse_outputs[gi]    <= 1'b0;
          pulse_outputs_oe[gi] <= 1'b0;
        end else begin
          pulse_outputs[gi]    <= next_pin.lvl;
          pulse_outputs_oe[gi] <= next_pin.oe && !alt;
        end
      end
      if (gi >= 4) begin : g_alt
        always_ff @(posedge sys_clk) begin
          if (sys_rst) begin
            alternate_pulse_outputs[gi-4]    <= 1'b0;
            alternate_pulse_outputs_oe[gi-4] <= 1'b0;
          end else begin
            alternate_pulse_outputs[gi-4]    <= next_pin.lvl;
            alternate_pulse_outputs_oe[gi-4] <= next_pin.oe && alt;
          end
        end
      end
    end
  endgenerate

  // helpers for the checks below
  logic [3:0] gap;
  logic [3:0] mode_q;
  logic [4:0] mode_age;
  logic [8:0] hi_cnt;
  logic       period_ok;
  logic [3:0] mode;
  logic [3:0] exp_gap;
  assign mode    = {counter_clock_enable, counter_clock_divided,
                    peripheral_clock_select[`PCLK_HI], peripheral_clock_select[`PCLK_LO]};
  assign exp_gap = counter_clock_divided ? div_mask : 4'h0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gap      <= 4'h0;
      mode_q   <= 4'h0;
      mode_age <= 5'h00;
    end else begin
      mode_q <= mode;
      gap    <= tick ? 4'h0 : ((gap == 4'hf) ? gap : gap + 4'h1);
      if (mode != mode_q) begin
        mode_age <= 5'h00;
      end else if (mode_age != 5'h1f) begin
        mode_age <= mode_age + 5'h01;
      end
    end
  end

  // active steps of channel 8 over one whole period
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hi_cnt    <= 9'h000;
      period_ok <= 1'b0;
    end else begin
      if (tick) begin
        hi_cnt <= (shared_counter == 8'hff) ? 9'h000 : hi_cnt + {8'h00, raw[0]};
      end
      if (wr_v && hit(req, `OFS_DUTY)) begin
        period_ok <= 1'b0;
      end else if (tick && shared_counter == 8'hff) begin
        period_ok <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_rd_addr;
    take && !hwrite;
  endsequence
  sequence s_rd_done;
    !hreadyout ##1 hreadyout;
  endsequence
  a_ctr_hold: assert property (
    !tick |=> $stable(shared_counter))
    else $error("counter moved without a tick");
  a_ctr_step: assert property (
    tick |=> shared_counter == $past(shared_counter) + 8'h01)
    else $error("counter did not step by one");
  // mode_age lags the mode by one edge, so the edge right after a change is skipped too
  a_div_gap: assert property (
    tick && mode == mode_q && mode_age >= 5'h10 |-> gap == exp_gap)
    else $error("tick spacing does not match divider");
  a_reset_off: assert property (
    $past(sys_rst) |-> !counter_clock_enable && !counter_clock_divided && !tick)
    else $error("counter clock on after reset");
  a_read_wait: assert property (
    s_rd_addr |=> s_rd_done)
    else $error("read did not finish after one wait");
  a_sel_fixed: assert property (
    s_rd_addr ##0 (haddr == 32'h00000000) |=> ##1 hrdata[7:4] ==
      {counter_clock_enable, counter_clock_divided, 2'b10})
    else $error("select register fixed bits wrong");
  a_duty_gate: assert property (
    wr_v && hit(req, `OFS_DUTY) && !data_sel[3] |=> $stable(duty_value))
    else $error("duty changed with select top bit 0");
  a_pclk_lock: assert property (
    wr_v && hit(req, `OFS_PCLK) && flash_on |=> $stable(peripheral_clock_select))
    else $error("clock select written with flash window open");
  a_phase_out: assert property (
    port_dir[0] && waveform_drive_bits[0] |=>
      pulse_outputs[0] == $past(raw[0] ^ phase_invert_bits[0]) && pulse_outputs_oe[0])
    else $error("pin level does not follow waveform and phase");
  a_route_alt: assert property (
    port_route_control[1] && port_dir[7] |=>
      !pulse_outputs_oe[7] && alternate_pulse_outputs_oe[3])
    else $error("alternate routing not applied");
  a_duty_total: assert property (
    tick && shared_counter == 8'hff && period_ok |->
      hi_cnt + {8'h00, raw[0]} == {1'b0, duty_value[0]})
    else $error("active steps per period differ from duty");
endmodule

// file: test/tb_top.sv
// self-checking bench for the eight channel pwm timer
`timescale 1ns/10ps
module tb_top;
  import pwm_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } row_t;
  logic        sys_clk;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  pulse_outputs;
  logic [7:0]  pulse_outputs_oe;
  logic [3:0]  alternate_pulse_outputs;
  logic [3:0]  alternate_pulse_outputs_oe;
  int          errors;
  int          num_checks;
  int          cnt [8];
  int          gap;
  logic [31:0] rd;
  row_t        rows [10];
  pwm_timer dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pulse_outputs(pulse_outputs), .pulse_outputs_oe(pulse_outputs_oe),
    .alternate_pulse_outputs(alternate_pulse_outputs), .alternate_pulse_outputs_oe(alternate_pulse_outputs_oe)
  );
  // 25 mhz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one single ahb-lite transfer, entered and left right after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    r = hrdata;
    if (n >= 50) errors++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask
  // count high pin cycles over n cycles; gap between the first two rising edges of ch11,
  // scanned half a window longer since the window may open right on one of its edges
  task automatic measure(input int n);
    int   p1;
    int   i;
    logic prev;
    p1 = -1;
    gap = 0;
    prev = 1'b1;
    for (i = 0; i < 8; i++) cnt[i] = 0;
    repeat (20) @(posedge sys_clk);
    for (int t = 0; t < n + n / 2; t++) begin
      @(negedge sys_clk);
      if (t < n) begin
        for (i = 0; i < 8; i++) cnt[i] += (pulse_outputs[i] === 1'b1);
      end
      if (pulse_outputs[3] === 1'b1 && prev !== 1'b1 && gap == 0) begin
        if (p1 >= 0) gap = t - p1;
        else p1 = t;
      end
      prev = pulse_outputs[3];
    end
    @(posedge sys_clk);
  endtask
  // watchdog well past the roughly 13000 cycles the tests take
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    finish_test();
  end
  initial begin
    errors = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rows = '{'{8'h00, 8'hdf, 8'hef}, '{8'h00, 8'h10, 8'h20}, '{8'h08, 8'ha5, 8'ha5}, '{8'h0c, 8'h3c, 8'h3c},
             '{8'h14, 8'hff, 8'h06}, '{8'h18, 8'hf7, 8'hf7}, '{8'h1c, 8'h5a, 8'h5a}, '{8'h20, 8'hc3, 8'hc3},
             '{8'h40, 8'h77, 8'h00}, '{8'h00, 8'h07, 8'h27}};
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    check("pins after reset", {pulse_outputs_oe, alternate_pulse_outputs_oe, hreadyout}, 13'h0001);
    // reset values; the duty window with select 0 reads 0
    for (int a = 0; a <= 8'h20; a += 4) begin
      xfer(1'b0, a[7:0], 8'h00, rd);
      check("reset value", rd, (a == 0) ? 32'h20 : 32'h0);
    end
    $display("test reset done");
    // plain register rows: write, then read back at once
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      xfer(1'b0, rows[i].addr, 8'h00, rd);
      check("register row", rd, {24'h0, rows[i].rexp});
      check("bus response", hresp, 32'h0);
    end
    wr(8'h04, 8'h99);
    xfer(1'b0, 8'h04, 8'h00, rd);
    check("duty window unselected", rd, 32'h0);
    $display("test rows done");
    // eight independent duty registers through the select field
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 8'h08 + i[7:0]);
      wr(8'h04, 8'h21 * i[7:0] + 8'h03);
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 8'h08 + i[7:0]);
      xfer(1'b0, 8'h04, 8'h00, rd);
      check("duty readback", rd, {24'h0, 8'h21 * i[7:0] + 8'h03});
    end
    $display("test duty registers done");
    // waveforms: ch8 0x81, ch9 0x00, ch10 0x40 inverted, ch11 0x02, ch15 0xff
    wr(8'h1c, 8'hff);
    wr(8'h0c, 8'hff);
    wr(8'h08, 8'h04);
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h08); wr(8'h04, 8'h81);
    wr(8'h00, 8'h09); wr(8'h04, 8'h00);
    wr(8'h00, 8'h0a); wr(8'h04, 8'h40);
    wr(8'h00, 8'h0b); wr(8'h04, 8'h02);
    wr(8'h00, 8'h0f); wr(8'h04, 8'hff);
    for (int k = -1; k < 4; k++) begin
      int div;
      div = (k < 0) ? 1 : (2 << k);
      if (k >= 0) wr(8'h10, k[1:0] << 1);
      wr(8'h00, (k < 0) ? 8'h80 : 8'hc0);
      measure(256 * div);
      check("ch8 high", cnt[0], 129 * div);
      check("ch9 high", cnt[1], 0);
      check("ch10 high", cnt[2], 192 * div);
      check("ch11 high", cnt[3], 2 * div);
      check("ch11 gap", gap, 128 * div);
      check("ch15 high", cnt[7], 255 * div);
    end
    $display("test waveforms done");
    // counter clock off: every pin holds its level
    wr(8'h00, 8'h00);
    measure(256);
    for (int i = 0; i < 8; i++) check("held pin", (cnt[i] == 0 || cnt[i] == 256), 1);
    $display("test clock off done");
    // clock select register locked while the flash window bit is set
    wr(8'h18, 8'h08);
    wr(8'h10, 8'h02);
    xfer(1'b0, 8'h10, 8'h00, rd);
    check("locked clock select", rd, 32'h0);
    wr(8'h18, 8'h00);
    xfer(1'b0, 8'h10, 8'h00, rd);
    check("clock select kept", rd, 32'h06);
    $display("test clock lock done");
    // port output, port input and alternate routing
    wr(8'h0c, 8'h00);
    wr(8'h20, 8'ha5);
    repeat (3) @(posedge sys_clk);
    check("port output", {pulse_outputs, pulse_outputs_oe}, 16'ha5ff);
    wr(8'h1c, 8'h00);
    repeat (3) @(posedge sys_clk);
    check("port input", pulse_outputs_oe, 8'h00);
    wr(8'h1c, 8'hff);
    wr(8'h14, 8'h04);
    repeat (3) @(posedge sys_clk);
    check("alternate oe", {alternate_pulse_outputs_oe, pulse_outputs_oe[7:6]}, 6'b110000);
    check("alternate level", alternate_pulse_outputs, 4'ha);
    $display("test pins done");
    finish_test();
  end
endmodule
